// ===== src/i2c_mem_pkg.sv
`default_nettype none
package i2c_mem_pkg;
  localparam int         ADDR_WIDTH = 15;
  localparam int         DATA_WIDTH = 8;
  localparam int         BUF_DEPTH  = 2;
  localparam logic [3:0] TYPE_CODE  = 4'hA;
  localparam logic [3:0] BIT_LAST   = 4'h7;
  localparam logic [3:0] ACK_SLOT   = 4'h8;
  localparam logic [3:0] BIT_FIRST  = 4'h0;
  localparam logic [3:0] BIT_WAIT   = 4'hF;
  localparam logic [14:0] ADDR_RESET = 15'h0000;
  localparam logic [14:0] ADDR_STEP  = 15'h0001;
  localparam logic [1:0]  FILL_FULL  = 2'h2;
  localparam logic [1:0]  FILL_EMPTY = 2'h0;
  localparam logic [1:0]  FILL_ONE   = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_AHI  = 3'b010,
    ST_ALO  = 3'b011,
    ST_WR   = 3'b100,
    ST_RD   = 3'b101
  } state_t;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
  } wr_entry_t;
endpackage
`default_nettype wire

// ===== src/i2c_mem_slave.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_mem_slave
  import i2c_mem_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int DEPTH  = BUF_DEPTH
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       wp_pin,
  input  wire logic       strap_addr_bit2,
  input  wire logic       strap_addr_bit1,
  input  wire logic       strap_addr_bit0,
  input  wire logic       commit_hold,
  output logic            bus_selected,
  output logic [1:0]      buf_level
);

  if (ADDR_W != ADDR_WIDTH || DEPTH != BUF_DEPTH) begin : g_check
    $error("Only a 15-bit address and a two-entry buffer are supported");
  end

  localparam int NPINS = 6;

  // Pin synchronisers
  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] pin_meta;
  logic [NPINS-1:0] pin_sync;
  logic             scl_prev;
  logic             sda_prev;

  assign pin_raw = {scl_in, sda_in, wp_pin,
                    strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};

  genvar gi;
  for (gi = 0; gi < NPINS; gi++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (rst) begin
        pin_meta[gi] <= 1'b1;
        pin_sync[gi] <= 1'b1;
      end else begin
        pin_meta[gi] <= pin_raw[gi];
        pin_sync[gi] <= pin_meta[gi];
      end
    end
  end

  logic       scl_s;
  logic       sda_s;
  logic       wp_s;
  logic [2:0] strap_code;

  assign scl_s      = pin_sync[5];
  assign sda_s      = pin_sync[4];
  assign wp_s       = pin_sync[3];
  assign strap_code = pin_sync[2:0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s & ~scl_prev;
  assign scl_fall  = ~scl_s & scl_prev;
  assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;

  // Array and write buffer
  logic [7:0]  mem [0:(1<<ADDR_WIDTH)-1];
  wr_entry_t   buf_q [0:BUF_DEPTH-1];
  logic        buf_wp;
  logic        buf_rp;
  logic [1:0]  buf_fill;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic        push;
  logic        push_fire;
  logic        drain_fire;
  wr_entry_t   push_entry;
  wr_entry_t   head;

  // Transfer state
  state_t      state;
  state_t      next_state;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic [7:0]  rx_shift;
  logic [7:0]  next_rx_shift;
  logic [7:0]  tx_shift;
  logic [7:0]  next_tx_shift;
  logic [6:0]  addr_hi;
  logic [6:0]  next_addr_hi;
  logic [14:0] addr_cnt;
  logic [14:0] next_addr_cnt;
  logic        next_sda_oe;
  logic        master_ack;
  logic        next_master_ack;

  logic        rx_state;
  logic        dev_match;
  logic        ack_ok;
  logic        ack_end;
  logic [7:0]  rd_data;
  logic [14:0] addr_inc;

  assign dev_match = (rx_shift[7:4] == TYPE_CODE)
                   && (rx_shift[3:1] == strap_code);

  assign rx_state = (state == ST_DEV) || (state == ST_AHI)
                 || (state == ST_ALO) || (state == ST_WR);

  // never busy; refusals are a device code mismatch and a full buffer while write protect is off
  assign ack_ok = (state == ST_DEV) ? dev_match
                : (state == ST_WR)  ? (buf_in_ready | wp_s)
                : 1'b1;

  assign ack_end  = scl_fall && (bit_cnt == ACK_SLOT);
  assign addr_inc = addr_cnt + ADDR_STEP;
  // Reads bypass the buffer; a held commit can show stale data
  assign rd_data  = mem[addr_cnt];

  assign push_entry.addr = addr_cnt;
  assign push_entry.data = rx_shift;

  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_rx_shift   = rx_shift;
    next_tx_shift   = tx_shift;
    next_addr_hi    = addr_hi;
    next_addr_cnt   = addr_cnt;
    next_sda_oe     = sda_oe;
    next_master_ack = master_ack;
    push            = 1'b0;
    if (start_det) begin
      next_state   = ST_DEV;
      // Clock fall closing the start is no data bit
      next_bit_cnt = BIT_WAIT;
      next_sda_oe  = 1'b0;
    end else if (stop_det) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else if (rx_state) begin
      if (scl_rise && bit_cnt != ACK_SLOT) begin
        next_rx_shift = {rx_shift[6:0], sda_s};
      end
      if (scl_fall && bit_cnt == BIT_WAIT) begin
        next_bit_cnt = BIT_FIRST;
      end else if (scl_fall && bit_cnt < BIT_LAST) begin
        next_bit_cnt = bit_cnt + 4'h1;
      end else if (scl_fall && bit_cnt == BIT_LAST) begin
        next_bit_cnt = ACK_SLOT;
        next_sda_oe  = ack_ok;
        if (!ack_ok && state == ST_DEV) begin
          next_state = ST_IDLE;
        end
      end else if (ack_end) begin
        next_bit_cnt = BIT_FIRST;
        next_sda_oe  = 1'b0;
        case (state)
          ST_DEV: begin
            if (rx_shift[0]) begin
              next_state    = ST_RD;
              next_tx_shift = rd_data;
              next_addr_cnt = addr_inc;
              next_sda_oe   = ~rd_data[7];
            end else begin
              next_state = ST_AHI;
            end
          end
          ST_AHI: begin
            next_addr_hi = rx_shift[6:0];
            next_state   = ST_ALO;
          end
          ST_ALO: begin
            next_addr_cnt = {addr_hi, rx_shift};
            next_state    = ST_WR;
          end
          ST_WR: begin
            if (sda_oe) begin
              push          = ~wp_s;
              next_addr_cnt = addr_inc;
            end
          end
          default: begin
            next_state = ST_IDLE;
          end
        endcase
      end
    end else if (state == ST_RD) begin
      if (scl_rise && bit_cnt == ACK_SLOT) begin
        next_master_ack = ~sda_s;
      end
      if (scl_fall && bit_cnt < BIT_LAST) begin
        next_bit_cnt  = bit_cnt + 4'h1;
        next_tx_shift = {tx_shift[6:0], 1'b0};
        next_sda_oe   = ~tx_shift[6];
      end else if (scl_fall && bit_cnt == BIT_LAST) begin
        next_bit_cnt = ACK_SLOT;
        next_sda_oe  = 1'b0;
      end else if (ack_end) begin
        next_bit_cnt = BIT_FIRST;
        if (master_ack) begin
          next_tx_shift = rd_data;
          next_addr_cnt = addr_inc;
          next_sda_oe   = ~rd_data[7];
        end else begin
          next_state  = ST_IDLE;
          next_sda_oe = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state      <= ST_IDLE;
      bit_cnt    <= BIT_FIRST;
      sda_oe     <= 1'b0;
      master_ack <= 1'b0;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      sda_oe     <= next_sda_oe;
      master_ack <= next_master_ack;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      addr_hi  <= 7'h00;
    end else begin
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
      addr_hi  <= next_addr_hi;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_cnt <= ADDR_RESET;
    end else begin
      addr_cnt <= next_addr_cnt;
    end
  end

  assign push_fire     = push & buf_in_ready;
  assign buf_in_ready  = (buf_fill != FILL_FULL);
  assign buf_out_valid = (buf_fill != FILL_EMPTY);
  assign drain_fire    = buf_out_valid & ~commit_hold;
  assign head          = buf_q[buf_rp];

  always_ff @(posedge mclk) begin
    if (push_fire) begin
      buf_q[buf_wp] <= push_entry;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      buf_wp   <= 1'b0;
      buf_rp   <= 1'b0;
      buf_fill <= FILL_EMPTY;
    end else begin
      buf_wp <= buf_wp ^ push_fire;
      buf_rp <= buf_rp ^ drain_fire;
      if (push_fire && !drain_fire) begin
        buf_fill <= buf_fill + FILL_ONE;
      end else if (drain_fire && !push_fire) begin
        buf_fill <= buf_fill - FILL_ONE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (drain_fire) begin
      mem[head.addr] <= head.data;
    end
  end

  assign sda_out      = 1'b0;
  assign bus_selected = (state != ST_IDLE);
  assign buf_level    = buf_fill;

endmodule
`default_nettype wire

// ===== sim/i2c_mem_slave_props.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_mem_slave_props
  import i2c_mem_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int DEPTH  = BUF_DEPTH
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       commit_hold,
  input wire logic       bus_selected,
  input wire logic [1:0] buf_level
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  od_low_a: assert property (sda_out == 1'h0)
    else $error("sda_out driven high");
  // Sync lag puts the change three cycles into the low phase
  oe_edge_a: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
    else $error("sda_oe moved outside scl low");
  ack_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*5])
    else $error("pull low too short");
  sel_drive_a: assert property (sda_oe |-> bus_selected)
    else $error("driving while idle");
  sel_start_a: assert property ($rose(bus_selected) |-> $past(scl_in, 3))
    else $error("selected without start");
  fill_max_a: assert property (buf_level <= FILL_FULL)
    else $error("buffer level over two");
  drain_one_a: assert property (buf_level == FILL_ONE && !commit_hold
    |=> buf_level == FILL_EMPTY)
    else $error("entry not committed");
  hold_keep_a: assert property (commit_hold && buf_level != FILL_EMPTY
    |=> buf_level >= $past(buf_level))
    else $error("drained while held");
endmodule
bind i2c_mem_slave i2c_mem_slave_props #(.ADDR_W(ADDR_W), .DEPTH(DEPTH)) chk_u (
  .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .commit_hold(commit_hold), .bus_selected(bus_selected), .buf_level(buf_level));
`default_nettype wire

// ===== sim/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input  wire logic mclk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_low
);
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // data moves only while clock low
  task automatic bit1(input logic b, output logic r);
    w(2);
    sda_low <= ~b;
    w(2);
    scl <= 1'h1;
    w(4);
    r = sda;
    scl <= 1'h0;
  endtask
  // nine clocks per byte, msb first
  task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) bit1(tx[i], rx[i]);
  endtask
  // Long wait lets a slave ack release before clock rises
  task automatic start();
    w(2);
    sda_low <= 1'h0;
    w(4);
    scl <= 1'h1;
    w(4);
    sda_low <= 1'h1;
    w(4);
    scl <= 1'h0;
  endtask
  task automatic stop();
    w(2);
    sda_low <= 1'h1;
    w(4);
    scl <= 1'h1;
    w(4);
    sda_low <= 1'h0;
    w(4);
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_i2c_mem_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_mem_slave
  import i2c_mem_pkg::*;
();
  logic        mclk, rst, sda_out, sda_oe, wp_pin, commit_hold, bus_selected;
  logic        scl, sda_low, r;
  logic [2:0]  strap;
  logic [1:0]  buf_level;
  logic [14:0] a;
  logic [7:0]  d;
  logic [8:0]  rx;
  logic [7:0]  mem [logic [14:0]];
  int          n_mismatch, comparisons;
  wire         sda;
  // Pull-up wins unless someone pulls low
  assign sda = ~sda_low & ~(sda_oe & ~sda_out);
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  i2c_mem_slave dut_u (
    .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .wp_pin(wp_pin), .strap_addr_bit2(strap[2]),
    .strap_addr_bit1(strap[1]), .strap_addr_bit0(strap[0]),
    .commit_hold(commit_hold), .bus_selected(bus_selected), .buf_level(buf_level));
  i2c_master_model partner_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(input logic [7:0] v, input logic ack, input string nm);
    partner_u.byte9({v, 1'h1}, rx);
    chk({7'h00, ~rx[0]}, {7'h00, ack}, nm);
  endtask
  task automatic set_addr(input logic [14:0] ad);
    partner_u.start();
    send({TYPE_CODE, strap, 1'h0}, 1'h1, "dev_w");
    send({1'h0, ad[14:8]}, 1'h1, "addr_hi");
    send(ad[7:0], 1'h1, "addr_lo");
  endtask
  task automatic wr(input logic [14:0] ad, input int n);
    set_addr(ad);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      send(d, 1'h1, "wdata");
      if (!wp_pin) mem[15'(ad + i)] = d;
    end
    partner_u.stop();
  endtask
  task automatic rd(input logic [14:0] ad, input int n);
    partner_u.start();
    send({TYPE_CODE, strap, 1'h1}, 1'h1, "dev_r");
    for (int i = 0; i < n; i++) begin
      partner_u.byte9({8'hFF, 1'(i == n - 1)}, rx);
      chk(rx[8:1], mem[15'(ad + i)], "rdata");
    end
    partner_u.stop();
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    rst = 1'h1;
    wp_pin = 1'h0;
    commit_hold = 1'h0;
    void'($urandom(6));
    strap = 3'($urandom);
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    repeat (6) @(posedge mclk);
    wr(15'h7FFE, 4);
    set_addr(15'h7FFE);
    rd(15'h7FFE, 3);
    rd(15'h0001, 1);
    $display("wrap write and reads done");
    for (int k = 0; k < 3; k++) begin
      a = 15'($urandom);
      wr(a, 2);
      set_addr(a);
      rd(a, 2);
    end
    $display("random transfers done");
    wp_pin <= 1'h1;
    wr(15'h0001, 1);
    wp_pin <= 1'h0;
    set_addr(15'h0001);
    rd(15'h0001, 1);
    $display("protect done");
    for (int k = 0; k < 4; k++) begin
      partner_u.start();
      send({k == 3 ? 4'hB : TYPE_CODE, strap ^ (3'h1 << k), 1'h0}, 1'h0, "dev_bad");
      chk({7'h00, bus_selected}, 8'h00, "sel_bad");
      partner_u.stop();
    end
    partner_u.start();
    send({TYPE_CODE, strap, 1'h0}, 1'h1, "dev_w");
    for (int k = 0; k < 4; k++) partner_u.bit1(1'h0, r);
    partner_u.stop();
    chk({7'h00, bus_selected}, 8'h00, "abort");
    $display("refusal and abort done");
    commit_hold <= 1'h1;
    set_addr(15'h0100);
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      send(d, 1'(k < 2), "fill");
      if (k < 2) mem[15'(15'h0100 + k)] = d;
    end
    chk({6'h00, buf_level}, 8'h02, "level_full");
    partner_u.stop();
    commit_hold <= 1'h0;
    for (int t = 0; t < 20 && buf_level != FILL_EMPTY; t++) @(posedge mclk);
    chk({6'h00, buf_level}, 8'h00, "level_empty");
    set_addr(15'h0100);
    rd(15'h0100, 2);
    $display("buffer stall done");
    end_of_test();
  end
endmodule
`default_nettype wire
